// ---- ras_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module ras_host_model (
	input  wire logic        sys_clk,
	output var  logic [11:0] awaddr,
	output var  logic        awvalid,
	input  wire logic        awready,
	output var  logic [31:0] wdata,
	output var  logic [3:0]  wstrb,
	output var  logic        wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output var  logic        bready,
	output var  logic [11:0] araddr,
	output var  logic        arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output var  logic        rready
);
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, araddr, arvalid} = '0;
		bready = 1'b1;
		rready = 1'b1;
	end

	// Write: both channels offered, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw && w)) begin
			@(posedge sys_clk);
			if (awready === 1'b1 && !aw) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1 && !w) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1)
			@(posedge sys_clk);
		rs = bresp;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
		araddr <= a;
		arvalid <= 1'b1;
		do
			@(posedge sys_clk);
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1)
			@(posedge sys_clk);
		d = rdata;
		rs = rresp;
	endtask
endmodule
`default_nettype wire

// ---- ras_inv_mem.sv ----
`timescale 1ns/100ps
`default_nettype none
module ras_inv_mem (
	input  wire logic       sys_clk,
	input  wire logic       we,
	input  wire logic [7:0] wAddr,
	input  wire logic [7:0] wData,
	input  wire logic       re,
	input  wire logic [7:0] rAddr,
	output var  logic [7:0] rData_r
);
	import ras_pkg::*;
	logic [7:0] mem [0:INV_DEPTH-1];

	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem[wAddr] <= wData;
		end
		if (re) begin
			rData_r <= mem[rAddr];
		end
	end
endmodule
`default_nettype wire

// ---- ras_pkg.sv ----
`default_nettype none
package ras_pkg;
	localparam int CLK_HZ = 125_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam int CS_TO_MS = 200;
	localparam int WD_MS = 70;
	localparam int CL_NOM_S = 5;
	localparam int CL_FADE_S = 30;
	localparam int CL_CHK_S = 5;
	localparam int PC_TO_MIN = 5;
	localparam logic [18:0] CS_TO_CNT = 19'(CS_TO_MS / TICK_MS);
	localparam logic [18:0] WD_CNT = 19'(WD_MS / TICK_MS);
	localparam logic [18:0] CL_NOM_CNT = 19'(CL_NOM_S * 1000 / TICK_MS);
	localparam logic [18:0] CL_FADE_CNT = 19'(CL_FADE_S * 1000 / TICK_MS);
	localparam logic [18:0] CL_CHK_CNT = 19'(CL_CHK_S * 1000 / TICK_MS);
	localparam logic [18:0] PC_TO_CNT = 19'(PC_TO_MIN * 60000 / TICK_MS);
	localparam logic [18:0] SW_RATE_RST = 19'h01388;
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_WDOG = 12'h004;
	localparam logic [11:0] OFS_CTL_CMD = 12'h008;
	localparam logic [11:0] OFS_NC_PROV = 12'h00c;
	localparam logic [11:0] OFS_RLY_EN = 12'h010;
	localparam logic [11:0] OFS_SW_RATE = 12'h014;
	localparam logic [11:0] OFS_RLY_ACT = 12'h018;
	localparam logic [11:0] OFS_IN_STAT = 12'h01c;
	localparam logic [11:0] OFS_CL_FLAG = 12'h020;
	localparam logic [1:0] INV_SEL = 2'h1;
	localparam int INV_DEPTH = 256;
	localparam int CTRL_HOTSTBY = 0;
	localparam int CTRL_PCTO_EN = 1;
	localparam int CTRL_MANUAL = 2;
	localparam int N_ALM = 8;
	localparam int N_STS = 7;
	localparam int N_CTL = 6;
	localparam int N_RLY = N_ALM + N_STS + N_CTL;
	localparam int ALM_PATH = 0;
	localparam int ALM_INLOSS = 1;
	localparam int ALM_XMT_A = 2;
	localparam int ALM_RCV_A = 4;
	localparam int ALM_PSU = 6;
	localparam int ALM_CTLFAIL = 7;
	localparam int STS_OFFNORM = 6;
	localparam logic [20:0] RLY_EN_RST = 21'h1fffff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	typedef enum logic [1:0] {
		CL_IDLE   = 2'b00,
		CL_WAIT   = 2'b01,
		CL_CHECK  = 2'b10,
		CL_REPEAT = 2'b11
	} ras_cl_e;
endpackage
`default_nettype wire

// ---- ras_relay_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module ras_relay_top #(
	parameter int TICK_CYC = ras_pkg::TICK_CYC
) (
	input  wire logic                       sys_clk,
	input  wire logic                       rst,
	input  wire logic [ras_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output var  logic                       s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output var  logic                       s_axi_wready,
	output var  logic [1:0]                 s_axi_bresp,
	output var  logic                       s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [ras_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output var  logic                       s_axi_arready,
	output var  logic [31:0]                s_axi_rdata,
	output var  logic [1:0]                 s_axi_rresp,
	output var  logic                       s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic [3:0]                 pathFault,
	input  wire logic [2:0]                 inputLoss,
	input  wire logic [1:0]                 txSyncAlm,
	input  wire logic [1:0]                 rfPowerAlm,
	input  wire logic [1:0]                 muxInLoss,
	input  wire logic [1:0]                 channelAlm,
	input  wire logic [1:0]                 rxFrameLoss,
	input  wire logic [1:0]                 eyeClosure,
	input  wire logic [1:0]                 lowSigLevel,
	input  wire logic [1:0]                 supplyFail,
	input  wire logic [1:0]                 pwrCtlActive,
	input  wire logic [1:0]                 dnstreamLoss,
	input  wire logic [5:0]                 inService,
	input  wire logic [7:0]                 offNormal,
	input  wire logic [5:0]                 ctrlStatus,
	output var  logic [ras_pkg::N_ALM-1:0]  alarmCoil,
	output var  logic [ras_pkg::N_STS-1:0]  statusCoil,
	output var  logic [ras_pkg::N_CTL-1:0]  ctrlCoil,
	output var  logic                       txSwitchReq,
	output var  logic                       moduleReset
);
	import ras_pkg::*;

	localparam int IN_W = 47;
	logic [IN_W-1:0] inRaw;
	logic [IN_W-1:0] inS0_r;
	logic [IN_W-1:0] inS1_r;
	logic [3:0]      pathS;
	logic [2:0]      inLossS;
	logic [1:0]      txSyncS, rfPwrS, muxLossS, chanS, frmLossS, eyeS, lowSigS;
	logic [1:0]      psFailS, pcActS, dsLossS;
	logic [5:0]      inSvcS;
	logic [7:0]      offNormS;
	logic [5:0]      ctlStsS;

	assign inRaw = {pathFault, inputLoss, txSyncAlm, rfPowerAlm, muxInLoss, channelAlm,
		rxFrameLoss, eyeClosure, lowSigLevel, supplyFail, pwrCtlActive, dnstreamLoss,
		inService, offNormal, ctrlStatus};
	assign {pathS, inLossS, txSyncS, rfPwrS, muxLossS, chanS, frmLossS, eyeS, lowSigS,
		psFailS, pcActS, dsLossS, inSvcS, offNormS, ctlStsS} = inS1_r;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			inS0_r <= '0;
			inS1_r <= '0;
		end else begin
			inS0_r <= inRaw;
			inS1_r <= inS0_r;
		end
	end

	// Millisecond enable
	logic [16:0] tickCnt_r;
	logic        tick_r;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tickCnt_r <= '0;
			tick_r <= 1'b0;
		end else if (tickCnt_r == 17'(TICK_CYC - 1)) begin
			tickCnt_r <= '0;
			tick_r <= 1'b1;
		end else begin
			tickCnt_r <= tickCnt_r + 17'h00001;
			tick_r <= 1'b0;
		end
	end

	logic              awHeld_r, wHeld_r, awready_r, wready_r, bvalid_r;
	logic [1:0]        bresp_r;
	logic [ADDR_W-1:0] wAddr_r;
	logic [31:0]       wData_r;
	logic [3:0]        wStrb_r;
	logic              arready_r, rvalid_r, rdPend_r;
	logic [1:0]        rresp_r;
	logic [31:0]       rdata_r;
	logic [ADDR_W-1:0] rdAddr_r;
	logic              doWr, arTake, csPulse, memWe;
	logic [7:0]        memQ;
	logic [2:0]        ctrl_r;
	logic              wdTog_r;
	logic [5:0]        ctlCmd_r;
	logic [20:0]       ncProv_r, rlyEn_r, act_r, coil_r;
	logic [18:0]       swRate_r;
	logic [1:0]        comLoss_r, pcTo;
	logic              ctrlFail_r, wdArm_r, modRst_r, txSw_r;
	ras_cl_e           clSt_r;
	logic [32:0]       wOldV, rdV;
	logic [31:0]       wNew;

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Bit 32 marks a mapped address
	function automatic logic [32:0] regVal(input logic [ADDR_W-1:0] a);
		logic [32:0] v;
		v = {1'b1, 32'h0};
		case (a)
		OFS_CTRL: v[2:0] = ctrl_r;
		OFS_WDOG: v[0] = wdTog_r;
		OFS_CTL_CMD: v[5:0] = ctlCmd_r;
		OFS_NC_PROV: v[20:0] = ncProv_r;
		OFS_RLY_EN: v[20:0] = rlyEn_r;
		OFS_SW_RATE: v[18:0] = swRate_r;
		OFS_RLY_ACT: v[20:0] = act_r;
		OFS_IN_STAT: v[11:0] = {clSt_r, wdArm_r, ctrlFail_r, pcTo, ctlStsS};
		OFS_CL_FLAG: v[1:0] = comLoss_r;
		default: v[32] = (a[11:10] == INV_SEL);
		endcase
		return v;
	endfunction

	always_comb begin
		wOldV = regVal(wAddr_r);
		rdV = regVal(rdAddr_r);
		wNew = merge(wOldV[31:0], wData_r, wStrb_r);
	end

	assign doWr = awHeld_r && wHeld_r && !bvalid_r;
	assign arTake = s_axi_arvalid && arready_r;
	assign csPulse = (s_axi_awvalid && awready_r) || arTake;
	assign memWe = doWr && wAddr_r[11:10] == INV_SEL && wStrb_r[0];

	// Write channel: address and data taken in either order
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			wAddr_r <= '0;
			wData_r <= '0;
			wStrb_r <= '0;
		end else begin
			if (s_axi_awvalid && awready_r) begin
				awHeld_r <= 1'b1;
				awready_r <= 1'b0;
				wAddr_r <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
			end
			if (s_axi_wvalid && wready_r) begin
				wHeld_r <= 1'b1;
				wready_r <= 1'b0;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			if (doWr) begin
				bvalid_r <= 1'b1;
				bresp_r <= wOldV[32] ? RESP_OKAY : RESP_DECERR;
			end
			if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	// Read channel: answer two cycles after address taken
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdPend_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= '0;
			rdAddr_r <= '0;
		end else begin
			rdPend_r <= 1'b0;
			if (arTake) begin
				arready_r <= 1'b0;
				rdPend_r <= 1'b1;
				rdAddr_r <= {s_axi_araddr[ADDR_W-1:2], 2'b00};
			end
			if (rdPend_r) begin
				rvalid_r <= 1'b1;
				rresp_r <= rdV[32] ? RESP_OKAY : RESP_DECERR;
				rdata_r <= (rdAddr_r[11:10] == INV_SEL) ? {24'h0, memQ} : rdV[31:0];
			end
			if (rvalid_r && s_axi_rready) begin
				rvalid_r <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end

	ras_inv_mem u_inv (
		.sys_clk (sys_clk),
		.we      (memWe),
		.wAddr   (wAddr_r[9:2]),
		.wData   (wData_r[7:0]),
		.re      (arTake),
		.rAddr   (s_axi_araddr[9:2]),
		.rData_r (memQ)
	);

	// Software-written configuration
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= '0;
			wdTog_r <= 1'b0;
			ctlCmd_r <= '0;
			ncProv_r <= '0;
			rlyEn_r <= RLY_EN_RST;
			swRate_r <= SW_RATE_RST;
		end else begin
			if (doWr) begin
				case (wAddr_r)
				OFS_CTRL: ctrl_r <= wNew[2:0];
				OFS_WDOG: wdTog_r <= wNew[0];
				OFS_CTL_CMD: ctlCmd_r <= wNew[5:0];
				OFS_NC_PROV: ncProv_r <= wNew[20:0];
				OFS_RLY_EN: rlyEn_r <= wNew[20:0];
				OFS_SW_RATE: swRate_r <= wNew[18:0];
				default: ;
				endcase
			end
			if (modRst_r) begin
				ctlCmd_r <= '0;
			end
		end
	end

	// Card-select supervision
	logic [18:0] csMs_r;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			csMs_r <= '0;
			ctrlFail_r <= 1'b0;
		end else if (csPulse) begin
			csMs_r <= '0;
			ctrlFail_r <= 1'b0;
		end else if (tick_r && csMs_r < CS_TO_CNT) begin
			csMs_r <= csMs_r + 19'h00001;
		end else if (csMs_r >= CS_TO_CNT) begin
			ctrlFail_r <= 1'b1;
		end
	end

	// Two-stage watchdog
	logic [18:0] wdMs_r;
	logic        wdPrev_r, wdToggle;
	assign wdToggle = wdTog_r != wdPrev_r;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wdMs_r <= '0;
			wdPrev_r <= 1'b0;
			wdArm_r <= 1'b0;
			modRst_r <= 1'b0;
		end else begin
			wdPrev_r <= wdTog_r;
			modRst_r <= 1'b0;
			if (wdToggle) begin
				wdMs_r <= '0;
				wdArm_r <= 1'b0;
			end else if (tick_r) begin
				if (wdMs_r == WD_CNT - 19'h00001) begin
					wdMs_r <= '0;
					wdArm_r <= !wdArm_r;
					modRst_r <= wdArm_r;
				end else begin
					wdMs_r <= wdMs_r + 19'h00001;
				end
			end
		end
	end

	// Power-control timeout per side
	for (genvar s = 0; s < 2; s++) begin : g_pc
		logic [18:0] pcMs_r;
		logic        pcTo_r;
		assign pcTo[s] = pcTo_r;
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				pcMs_r <= '0;
				pcTo_r <= 1'b0;
			end else if (!pcActS[s] || !ctrl_r[CTRL_PCTO_EN]) begin
				pcMs_r <= '0;
				pcTo_r <= 1'b0;
			end else begin
				if (tick_r && pcMs_r < PC_TO_CNT) begin
					pcMs_r <= pcMs_r + 19'h00001;
				end
				pcTo_r <= pcMs_r >= PC_TO_CNT;
			end
		end
	end

	// Common loss sequencing
	logic        dsBoth, onSide, clSide_r, clSet;
	logic [18:0] clMs_r, clLim;
	assign dsBoth = &dsLossS;
	assign onSide = !inSvcS[0];
	assign clLim = pcActS[onSide] ? CL_FADE_CNT : CL_NOM_CNT;
	assign clSet = clSt_r == CL_CHECK && !dsBoth;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			clSt_r <= CL_IDLE;
			clMs_r <= '0;
			clSide_r <= 1'b0;
			txSw_r <= 1'b0;
		end else begin
			txSw_r <= 1'b0;
			if (tick_r) begin
				clMs_r <= clMs_r + 19'h00001;
			end
			case (clSt_r)
			CL_IDLE: begin
				clMs_r <= '0;
				if (dsBoth && ctrl_r[CTRL_HOTSTBY]) begin
					clSt_r <= CL_WAIT;
				end
			end
			CL_WAIT: begin
				if (!dsBoth) begin
					clSt_r <= CL_IDLE;
				end else if (clMs_r >= clLim) begin
					txSw_r <= 1'b1;
					clSide_r <= onSide;
					clMs_r <= '0;
					clSt_r <= CL_CHECK;
				end
			end
			CL_CHECK: begin
				if (!dsBoth) begin
					clSt_r <= CL_IDLE;
				end else if (clMs_r >= CL_CHK_CNT) begin
					txSw_r <= 1'b1;
					clMs_r <= '0;
					clSt_r <= CL_REPEAT;
				end
			end
			CL_REPEAT: begin
				if (!dsBoth) begin
					clSt_r <= CL_IDLE;
				end else if (clMs_r >= swRate_r) begin
					txSw_r <= 1'b1;
					clMs_r <= '0;
				end
			end
			default: clSt_r <= CL_IDLE;
			endcase
		end
	end

	// Flags cleared by writing ones; a new event wins
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			comLoss_r <= '0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (clSet && clSide_r == i[0]) begin
					comLoss_r[i] <= 1'b1;
				end else if (doWr && wAddr_r == OFS_CL_FLAG && wStrb_r[0] && wData_r[i]) begin
					comLoss_r[i] <= 1'b0;
				end
			end
		end
	end

	// Relay activity and coil drive
	logic [N_ALM-1:0] almAct;
	logic [N_STS-1:0] stsAct;
	always_comb begin
		almAct[ALM_PATH] = |pathS;
		almAct[ALM_INLOSS] = |inLossS;
		for (int s = 0; s < 2; s++) begin
			almAct[ALM_XMT_A + s] = txSyncS[s] | rfPwrS[s] | comLoss_r[s] | pcTo[s]
				| muxLossS[s];
			almAct[ALM_RCV_A + s] = chanS[s] | frmLossS[s] | eyeS[s] | lowSigS[s];
		end
		almAct[ALM_PSU] = |psFailS;
		almAct[ALM_CTLFAIL] = ctrlFail_r;
		stsAct[5:0] = inSvcS;
		stsAct[STS_OFFNORM] = ctrl_r[CTRL_MANUAL] | (|offNormS);
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			act_r <= '0;
			coil_r <= '0;
		end else begin
			act_r <= modRst_r ? '0 : {ctlCmd_r, stsAct, almAct};
			coil_r <= (act_r ^ ncProv_r) & rlyEn_r;
		end
	end

	assign alarmCoil = coil_r[N_ALM-1:0];
	assign statusCoil = coil_r[N_ALM +: N_STS];
	assign ctrlCoil = coil_r[N_ALM+N_STS +: N_CTL];
	assign txSwitchReq = txSw_r;
	assign moduleReset = modRst_r;
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	path_relay_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(|pathS) && !modRst_r |=> act_r[ALM_PATH]) else $error("path relay idle");
	loss_relay_a: assert property (@(posedge sys_clk) disable iff (rst)
		inLossS[2] && !modRst_r |=> act_r[ALM_INLOSS]) else $error("loss relay idle");
	xmt_relay_a: assert property (@(posedge sys_clk) disable iff (rst)
		comLoss_r[0] && !modRst_r |=> act_r[ALM_XMT_A]) else $error("xmt relay idle");
	rcv_relay_a: assert property (@(posedge sys_clk) disable iff (rst)
		lowSigS[0] && !modRst_r |=> act_r[ALM_RCV_A]) else $error("rcv relay idle");
	psu_relay_a: assert property (@(posedge sys_clk) disable iff (rst)
		psFailS[1] && !modRst_r |=> act_r[ALM_PSU]) else $error("supply relay idle");
	ctl_fail_a: assert property (@(posedge sys_clk) disable iff (rst)
		csPulse && !modRst_r |=> !ctrlFail_r ##1 !act_r[ALM_CTLFAIL])
		else $error("controller fail not rearmed");
	nc_coil_a: assert property (@(posedge sys_clk) disable iff (rst)
		act_r[0] && ncProv_r[0] && rlyEn_r[0] |=> !coil_r[0]) else $error("nc coil energized");
	in_svc_a: assert property (@(posedge sys_clk) disable iff (rst)
		inSvcS[2] && !modRst_r |=> act_r[N_ALM+2]) else $error("in service relay idle");
	off_norm_a: assert property (@(posedge sys_clk) disable iff (rst)
		ctrl_r[CTRL_MANUAL] && !modRst_r |=> act_r[N_ALM+STS_OFFNORM])
		else $error("off normal relay idle");
	ctl_cmd_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(ctlCmd_r[0]) && !modRst_r |=> act_r[N_ALM+N_STS]) else $error("control relay idle");
	wd_retrig_a: assert property (@(posedge sys_clk) disable iff (rst)
		wdToggle |=> wdMs_r == 19'h00000 && !wdArm_r) else $error("watchdog not retriggered");
	wd_fire_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(modRst_r) |-> $past(wdArm_r) && !wdArm_r) else $error("reset without first stage");
	cl_start_a: assert property (@(posedge sys_clk) disable iff (rst)
		clSt_r == CL_IDLE && dsBoth && ctrl_r[CTRL_HOTSTBY] |=> clSt_r == CL_WAIT)
		else $error("common loss wait not entered");
	cl_switch_a: assert property (@(posedge sys_clk) disable iff (rst)
		txSw_r && $past(clSt_r) == CL_WAIT |-> $past(clMs_r) >= $past(clLim))
		else $error("switch before delay");
	cl_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(comLoss_r[0]) |-> $past(clSt_r) == CL_CHECK) else $error("flag outside check");
	pc_to_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(pcTo[0]) |-> $past(ctrl_r[CTRL_PCTO_EN]) && $past(pcActS[0]))
		else $error("timeout not enabled");
	rd_lat_a: assert property (@(posedge sys_clk) disable iff (rst)
		arTake |-> ##2 rvalid_r) else $error("read answer late");
	mod_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
		modRst_r |=> act_r == '0) else $error("relays not cleared");
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import ras_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, r1, r2, d;
	logic [3:0]  wstrb, pathFault;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, txSwitchReq, moduleReset;
	logic [1:0]  bresp, rresp, rs, txSyncAlm, rfPowerAlm, muxInLoss, channelAlm;
	logic [1:0]  rxFrameLoss, eyeClosure, lowSigLevel, supplyFail;
	logic [1:0]  pwrCtlActive = 2'h0;
	logic [1:0]  dnstreamLoss = 2'h0;
	logic [2:0]  inputLoss;
	logic [5:0]  inService, ctrlStatus, ctrlCoil;
	logic [7:0]  offNormal, alarmCoil, k;
	logic [6:0]  statusCoil;
	logic [20:0] nc;
	int          fail_count = 0;
	int          n_checks = 0;
	int          seed = 69009;
	int          n;

	always #4 sys_clk = ~sys_clk;

	ras_host_model i_host (.sys_clk(sys_clk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	ras_relay_top #(.TICK_CYC(4)) i_dut (.sys_clk(sys_clk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pathFault(pathFault), .inputLoss(inputLoss), .txSyncAlm(txSyncAlm),
		.rfPowerAlm(rfPowerAlm), .muxInLoss(muxInLoss), .channelAlm(channelAlm),
		.rxFrameLoss(rxFrameLoss), .eyeClosure(eyeClosure), .lowSigLevel(lowSigLevel),
		.supplyFail(supplyFail), .pwrCtlActive(pwrCtlActive), .dnstreamLoss(dnstreamLoss),
		.inService(inService), .offNormal(offNormal), .ctrlStatus(ctrlStatus),
		.alarmCoil(alarmCoil), .statusCoil(statusCoil), .ctrlCoil(ctrlCoil),
		.txSwitchReq(txSwitchReq), .moduleReset(moduleReset));

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Status above alarms, active-high before polarity
	function automatic logic [14:0] expAs(input logic man);
		logic [1:0] x;
		logic [1:0] r;
		x = txSyncAlm | rfPowerAlm | muxInLoss;
		r = channelAlm | rxFrameLoss | eyeClosure | lowSigLevel;
		return {man | (|offNormal), inService, 1'b0, |supplyFail, r, x, |inputLoss, |pathFault};
	endfunction

	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#400000;
		fail_count++;
		give_verdict();
	end

	initial begin
		{pathFault, inputLoss, txSyncAlm, rfPowerAlm, muxInLoss, channelAlm, rxFrameLoss} = '0;
		{eyeClosure, lowSigLevel, supplyFail, inService, offNormal, ctrlStatus} = '0;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		chk("coils", 32'({alarmCoil, statusCoil, ctrlCoil, txSwitchReq, moduleReset}), 0);
		i_host.rd(OFS_SW_RATE, d, rs);
		chk("rate", d, 32'(SW_RATE_RST));
		i_host.rd(OFS_RLY_EN, d, rs);
		chk("enable", d, 32'(RLY_EN_RST));
		for (int i = 0; i < 24; i++) begin
			r1 = (i == 0) ? '0 : $random(seed);
			r2 = (i == 0) ? '0 : $random(seed);
			nc = (i < 2) ? '0 : 21'($random(seed));
			{pathFault, inputLoss, txSyncAlm, rfPowerAlm, muxInLoss, channelAlm, rxFrameLoss} <= r1[16:0];
			{eyeClosure, lowSigLevel, supplyFail, inService, offNormal, ctrlStatus} <= r2[25:0];
			i_host.wr(OFS_WDOG, 32'(i % 2), rs);
			i_host.wr(OFS_CTRL, {29'h0, r2[31:29]}, rs);
			i_host.wr(OFS_NC_PROV, 32'(nc), rs);
			i_host.wr(OFS_CTL_CMD, 32'(r1[22:17]), rs);
			repeat (8) @(posedge sys_clk);
			chk("relays", 32'({statusCoil, alarmCoil}), 32'(expAs(r2[31]) ^ nc[14:0]));
			chk("controls", 32'(ctrlCoil), 32'(r1[22:17] ^ nc[20:15]));
			i_host.rd(OFS_IN_STAT, d, rs);
			chk("ctrl status", 32'(d[5:0]), 32'(ctrlStatus));
		end
		for (int j = 0; j < 4; j++) begin
			k = (j == 0) ? 8'h00 : (j == 1) ? 8'hff : 8'($random(seed));
			r1 = $random(seed);
			i_host.wr({2'b01, k, 2'b00}, r1, rs);
			i_host.rd({2'b01, k, 2'b00}, d, rs);
			chk("inventory", 32'(d[7:0]), 32'(r1[7:0]));
		end
		i_host.wr(12'h100, 32'h1, rs);
		chk("bad write", 32'(rs), 32'(RESP_DECERR));
		i_host.rd(12'h100, d, rs);
		chk("bad read", {d[29:0], rs}, 32'(RESP_DECERR));
		i_host.wr(OFS_NC_PROV, 32'h0, rs);
		i_host.wr(OFS_CTL_CMD, 32'h3f, rs);
		i_host.wr(OFS_WDOG, 32'h0, rs);
		n = 0;
		while (moduleReset !== 1'b1 && n < 2000) begin
			@(posedge sys_clk);
			n++;
		end
		chk("wdog delay", 32'(n >= 540 && n <= 580), 32'h1);
		repeat (4) @(posedge sys_clk);
		chk("ctl after reset", 32'(ctrlCoil), 32'h0);
		repeat (756 - n) @(posedge sys_clk);
		chk("ctl fail early", 32'(alarmCoil[7]), 32'h0);
		repeat (80) @(posedge sys_clk);
		chk("ctl fail", 32'(alarmCoil[7]), 32'h1);
		i_host.rd(OFS_CTRL, d, rs);
		repeat (8) @(posedge sys_clk);
		chk("ctl fail rearm", 32'(alarmCoil[7]), 32'h0);
		// Common loss in hot standby, A side online, nominal path
		{txSyncAlm, rfPowerAlm, muxInLoss} <= '0;
		inService <= 6'h01;
		i_host.wr(OFS_CTRL, 32'h1, rs);
		dnstreamLoss <= 2'h3;
		n = 0;
		while (txSwitchReq !== 1'b1 && n < 25000) begin
			@(posedge sys_clk);
			n++;
		end
		chk("switch delay", 32'(n >= 19990 && n <= 20020), 32'h1);
		i_host.wr(OFS_WDOG, 32'h1, rs);
		dnstreamLoss <= 2'h0;
		repeat (8) @(posedge sys_clk);
		chk("xmt relay", 32'(alarmCoil[3:2]), 32'h1);
		i_host.rd(OFS_CL_FLAG, d, rs);
		chk("cl flag", d, 32'h1);
		i_host.wr(OFS_CL_FLAG, 32'h1, rs);
		i_host.rd(OFS_CL_FLAG, d, rs);
		chk("cl clear", d, 32'h0);
		give_verdict();
	end
endmodule
`default_nettype wire
